// >>> pkg/dac_seq_params.svh
// timing counts, field codes and reset values for the two-channel converter sequencer
// assumes a 50 MHz system clock; included by bare name
`ifndef DAC_SEQ_PARAMS_SVH
`define DAC_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS 20
`define SAMPLE_INTERVAL_NS 320
// least time, so round up to whole cycles
`define SAMPLE_CYC ((`SAMPLE_INTERVAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_CNT_W 5

`define REFRESH_FIELD_W 4
`define REFRESH_UNIT_CYC 64
`define REFRESH_CNT_W 10

`define CHAN_SEL_W 2
`define CHAN_SEL_SINGLE 2'h0
`define CHAN_SEL_DUAL 2'h2

`define VALUE_W 12
`define BYTE_W 8
`define VALUE_RST 12'h000
`define BYTE_RST 8'h00
`define OUT_EN_SINGLE 2'h1
`define OUT_EN_DUAL 2'h3

`endif

// >>> pkg/dac_seq_pkg.sv
// types shared by the converter sequencer files
// constants live in dac_seq_params.svh
package dac_seq_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_CONV = 2'b10
	} seqState_t;
endpackage

// >>> core/dac_value_assembler.sv
// holds one channel's low and high value bytes and assembles the 12-bit value
// assumes byte writes arrive from logic on clk_sys, one-cycle strobes
`include "dac_seq_params.svh"
`timescale 1ns/100ps
`default_nettype none

module dac_value_assembler (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// byte writes
	input wire logic lowWrite,
	input wire logic highWrite,
	input wire logic [7:0] wrData,
	input wire logic leftAlign,
	// assembled value and conversion request
	output logic [11:0] value,
	output logic convReq
);
	logic [7:0] lowByte_r, lowByte_nxt;
	logic [7:0] highByte_r, highByte_nxt;
	logic convReq_r, convReq_nxt;

	always_comb begin
		lowByte_nxt = lowWrite ? wrData : lowByte_r;
		highByte_nxt = highWrite ? wrData : highByte_r;
		// high byte write starts the conversion, so 8-bit left-aligned use needs only one write
		convReq_nxt = highWrite;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lowByte_r <= `BYTE_RST;
			highByte_r <= `BYTE_RST;
			convReq_r <= 1'b0;
		end else begin
			lowByte_r <= lowByte_nxt;
			highByte_r <= highByte_nxt;
			convReq_r <= convReq_nxt;
		end
	end

	// left: high holds bits 11..4; right: low holds 7..0, high nibble 11..8
	assign value = leftAlign ? {highByte_r, lowByte_r[7:4]} : {highByte_r[3:0], lowByte_r};
	assign convReq = convReq_r;

	property p_right_adjust;
		@(posedge clk_sys) disable iff (!nrst)
		(highWrite && !leftAlign) ##1 !leftAlign |-> value[11:8] == $past(wrData[3:0]);
	endproperty
	a_right_adjust: assert property (p_right_adjust) else $error("right-adjusted high nibble wrong");

	property p_left_adjust;
		@(posedge clk_sys) disable iff (!nrst)
		(highWrite && leftAlign) ##1 leftAlign |-> value[11:4] == $past(wrData);
	endproperty
	a_left_adjust: assert property (p_left_adjust) else $error("left-adjusted high byte wrong");

endmodule
`default_nettype wire

// >>> core/dac_refresh_timer.sv
// free-running refresh interval generator for dual-channel mode
// assumes refreshField is steady while enabled; zero field stops refresh
`include "dac_seq_params.svh"
`timescale 1ns/100ps
`default_nettype none

module dac_refresh_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control
	input wire logic enable,
	input wire logic [3:0] refreshField,
	// interval tick
	output logic tick
);
	logic [9:0] count_r, count_nxt;
	logic tick_r, tick_nxt;
	logic [9:0] periodLast;

	// period is field times the unit; only enable and the field touch the count
	assign periodLast = 10'(refreshField * `REFRESH_UNIT_CYC - 1);

	always_comb begin
		count_nxt = 10'h000;
		tick_nxt = 1'b0;
		if (enable && refreshField != 4'h0) begin
			if (count_r >= periodLast) begin
				tick_nxt = 1'b1;
			end else begin
				count_nxt = count_r + 10'h001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count_r <= 10'h000;
			tick_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

	property p_steady_count;
		@(posedge clk_sys) disable iff (!nrst)
		(enable && refreshField != 4'h0 && count_r < periodLast) ##1 (enable && $stable(refreshField))
			|-> count_r == $past(count_r) + 10'h001;
	endproperty
	a_steady_count: assert property (p_steady_count) else $error("refresh count disturbed");

endmodule
`default_nettype wire

// >>> core/dac_channel_sequencer.sv
// two-channel converter sequencer sharing one conversion block
// assumes value writes and event triggers come from logic on clk_sys
`include "dac_seq_params.svh"
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - start conversion on value write or event
// - two channels, own value registers, one converter
// - channel select field picks single or dual
// - single: channel 0 only, hold bypassed, enabled
// - dual: channels alternate, outputs held between
// - dual: each channel regularly refreshed
// - refresh interval from timing control field
// - refresh converts channel 0 then channel 1
// - extra conversions never shift refresh timing
// - default value is high nibble over low byte
// - left align bit selects left-aligned data
// - left aligned high write alone gives 8 MSB
module dac_channel_sequencer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// control fields
	input wire logic [1:0] channelSelectField,
	input wire logic [3:0] refreshTimingField,
	input wire logic leftAlignBit,
	// value byte writes, per channel
	input wire logic [1:0] lowWrite,
	input wire logic [1:0] highWrite,
	input wire logic [7:0] wrData,
	// event triggers, per channel
	input wire logic [1:0] eventTrig,
	// conversion block
	output logic [11:0] convData,
	output logic convChannel,
	output logic convStart,
	output logic convBusy,
	// output stage
	output logic [1:0] holdSampling,
	output logic [1:0] outEnable,
	output logic bypassHold
);
	logic dualMode;
	logic [11:0] chanValue [2];
	logic [1:0] writeReq;
	logic refreshTick;
	logic [1:0] newReq;

	dac_seq_pkg::seqState_t state_r, state_nxt;
	logic [4:0] sampleCnt_r, sampleCnt_nxt;
	logic [1:0] pend_r, pend_nxt;
	logic [1:0] clearMask;
	logic [11:0] convData_r, convData_nxt;
	logic convChannel_r, convChannel_nxt;
	logic convStart_r, convStart_nxt;
	logic convBusy_r, convBusy_nxt;
	logic [1:0] holdSampling_r, holdSampling_nxt;
	logic [1:0] outEnable_r, outEnable_nxt;
	logic bypassHold_r, bypassHold_nxt;

	// other field codes fall back to single channel
	assign dualMode = (channelSelectField == `CHAN_SEL_DUAL);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gChan
			dac_value_assembler uValue (
				.clk_sys(clk_sys),
				.nrst(nrst),
				.lowWrite(lowWrite[gi]),
				.highWrite(highWrite[gi]),
				.wrData(wrData),
				.leftAlign(leftAlignBit),
				.value(chanValue[gi]),
				.convReq(writeReq[gi])
			);
		end
	endgenerate

	dac_refresh_timer uRefresh (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.enable(dualMode),
		.refreshField(refreshTimingField),
		.tick(refreshTick)
	);

	// refresh asks for both; ch0 wins the arbiter, giving the 0-then-1 order
	always_comb begin
		newReq = writeReq | eventTrig;
		if (dualMode && refreshTick) begin
			newReq = newReq | 2'h3;
		end
		if (!dualMode) begin
			newReq[1] = 1'b0;
		end
	end

	always_comb begin
		state_nxt = state_r;
		sampleCnt_nxt = sampleCnt_r;
		clearMask = 2'h0;
		convData_nxt = convData_r;
		convChannel_nxt = convChannel_r;
		convStart_nxt = 1'b0;
		convBusy_nxt = convBusy_r;
		case (state_r)
			dac_seq_pkg::SEQ_IDLE: begin
				if (pend_r[0]) begin
					clearMask = 2'h1;
					convChannel_nxt = 1'b0;
					convData_nxt = chanValue[0];
					convStart_nxt = 1'b1;
					convBusy_nxt = 1'b1;
					sampleCnt_nxt = 5'h00;
					state_nxt = dac_seq_pkg::SEQ_CONV;
				end else if (pend_r[1] && dualMode) begin
					clearMask = 2'h2;
					convChannel_nxt = 1'b1;
					convData_nxt = chanValue[1];
					convStart_nxt = 1'b1;
					convBusy_nxt = 1'b1;
					sampleCnt_nxt = 5'h00;
					state_nxt = dac_seq_pkg::SEQ_CONV;
				end
			end
			dac_seq_pkg::SEQ_CONV: begin
				// one sample interval per conversion
				if (sampleCnt_r == 5'(`SAMPLE_CYC - 1)) begin
					convBusy_nxt = 1'b0;
					state_nxt = dac_seq_pkg::SEQ_IDLE;
				end else begin
					sampleCnt_nxt = sampleCnt_r + 5'h01;
				end
			end
			default: begin
				convBusy_nxt = 1'b0;
				state_nxt = dac_seq_pkg::SEQ_IDLE;
			end
		endcase
		// continuous drive: in single mode the converter input follows the channel 0 value every cycle
		if (!dualMode) begin
			convData_nxt = chanValue[0];
			convChannel_nxt = 1'b0;
		end
		// set after clear, so a request in the clearing cycle is kept
		pend_nxt = (pend_r & ~clearMask) | newReq;
		if (!dualMode) begin
			pend_nxt[1] = 1'b0;
		end
	end

	always_comb begin
		holdSampling_nxt = 2'h0;
		if (dualMode && state_nxt == dac_seq_pkg::SEQ_CONV) begin
			holdSampling_nxt[convChannel_nxt] = 1'b1;
		end
		outEnable_nxt = dualMode ? `OUT_EN_DUAL : `OUT_EN_SINGLE;
		bypassHold_nxt = !dualMode;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r <= dac_seq_pkg::SEQ_IDLE;
			sampleCnt_r <= 5'h00;
			pend_r <= 2'h0;
			convData_r <= `VALUE_RST;
			convChannel_r <= 1'b0;
			convStart_r <= 1'b0;
			convBusy_r <= 1'b0;
			holdSampling_r <= 2'h0;
			outEnable_r <= 2'h0;
			bypassHold_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			sampleCnt_r <= sampleCnt_nxt;
			pend_r <= pend_nxt;
			convData_r <= convData_nxt;
			convChannel_r <= convChannel_nxt;
			convStart_r <= convStart_nxt;
			convBusy_r <= convBusy_nxt;
			holdSampling_r <= holdSampling_nxt;
			outEnable_r <= outEnable_nxt;
			bypassHold_r <= bypassHold_nxt;
		end
	end

	assign convData = convData_r;
	assign convChannel = convChannel_r;
	assign convStart = convStart_r;
	assign convBusy = convBusy_r;
	assign holdSampling = holdSampling_r;
	assign outEnable = outEnable_r;
	assign bypassHold = bypassHold_r;

	sequence s_start0;
		convStart_r && !convChannel_r;
	endsequence

	sequence s_start1;
		convStart_r && convChannel_r;
	endsequence

	property p_sample_len;
		@(posedge clk_sys) disable iff (!nrst)
		convStart_r |-> convBusy_r ##16 !convBusy_r;
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sample interval length wrong");

	property p_single_mode;
		@(posedge clk_sys) disable iff (!nrst)
		!dualMode ##1 1'b1 |-> bypassHold_r && outEnable_r == 2'h1 && holdSampling_r == 2'h0;
	endproperty
	a_single_mode: assert property (p_single_mode) else $error("single mode output stage wrong");

	// continuous drive: converter input is channel 0 value, one cycle behind
	property p_single_data;
		@(posedge clk_sys) disable iff (!nrst)
		!dualMode ##1 !dualMode |-> convData_r == $past(chanValue[0]) && !convChannel_r;
	endproperty
	a_single_data: assert property (p_single_data) else $error("single mode data path wrong");

	property p_single_no_ch1;
		@(posedge clk_sys) disable iff (!nrst)
		s_start1 |-> !bypassHold_r;
	endproperty
	a_single_no_ch1: assert property (p_single_no_ch1) else $error("channel 1 converted in single mode");

	property p_priority;
		@(posedge clk_sys) disable iff (!nrst)
		(dualMode && state_r == dac_seq_pkg::SEQ_IDLE && pend_r == 2'h3) |=> s_start0 ##[16:17] s_start1;
	endproperty
	a_priority: assert property (p_priority) else $error("channel 0 not served first");

	property p_refresh_order;
		@(posedge clk_sys) disable iff (!nrst)
		(dualMode && refreshTick && pend_r == 2'h0 && state_r == dac_seq_pkg::SEQ_IDLE)
			|-> ##[1:2] s_start0 ##[16:17] s_start1;
	endproperty
	a_refresh_order: assert property (p_refresh_order) else $error("refresh order not 0 then 1");

	property p_event_start;
		@(posedge clk_sys) disable iff (!nrst)
		(eventTrig[0] && state_r == dac_seq_pkg::SEQ_IDLE && pend_r == 2'h0) |-> ##[1:2] s_start0;
	endproperty
	a_event_start: assert property (p_event_start) else $error("event did not start conversion");

	property p_hold_match;
		@(posedge clk_sys) disable iff (!nrst)
		holdSampling_r[1] |-> convBusy_r && convChannel_r && !holdSampling_r[0];
	endproperty
	a_hold_match: assert property (p_hold_match) else $error("hold stage not tied to channel");

	property p_start_data;
		@(posedge clk_sys) disable iff (!nrst)
		(state_r == dac_seq_pkg::SEQ_IDLE && pend_r[1] && !pend_r[0] && dualMode) |=>
			s_start1 and (convData_r == $past(chanValue[1]));
	endproperty
	a_start_data: assert property (p_start_data) else $error("channel 1 data not loaded");

endmodule
`default_nettype wire

// >>> dv/dac_output_stage_model.sv
// analog output stage model: two sample-and-hold cells and a bypass path
// assumes the sequencer outputs on clk_sys; values are digital stand-ins for voltages
`timescale 1ns/100ps
`default_nettype none

module dac_output_stage_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// from the sequencer
	input wire logic [11:0] convData,
	input wire logic [1:0] holdSampling,
	input wire logic bypassHold,
	// held levels
	output logic [11:0] heldValue0,
	output logic [11:0] heldValue1
);
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			heldValue0 <= 12'h000;
			heldValue1 <= 12'h000;
		end else begin
			// continuous drive tracks the converter, one cycle late
			if (bypassHold || holdSampling[0])
				heldValue0 <= convData;
			if (holdSampling[1] && !bypassHold)
				heldValue1 <= convData;
		end
	end
endmodule

`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the two-channel converter sequencer
// assumes the sequencer and the output stage model are compiled first
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

module tb_top;
	logic clk_sys, nrst, leftAlignBit, convChannel, convStart, convBusy, bypassHold;
	logic [1:0] channelSelectField, lowWrite, highWrite, eventTrig, holdSampling, outEnable;
	logic [3:0] refreshTimingField;
	logic [7:0] wrData;
	logic [11:0] convData, heldValue0, heldValue1;
	int numErrors = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int n;
	int k;
	time t0;

	dac_channel_sequencer dac_channel_sequencer_inst (.clk_sys(clk_sys), .nrst(nrst),
		.channelSelectField(channelSelectField), .refreshTimingField(refreshTimingField),
		.leftAlignBit(leftAlignBit), .lowWrite(lowWrite), .highWrite(highWrite), .wrData(wrData),
		.eventTrig(eventTrig), .convData(convData), .convChannel(convChannel), .convStart(convStart),
		.convBusy(convBusy), .holdSampling(holdSampling), .outEnable(outEnable), .bypassHold(bypassHold));
	dac_output_stage_model dac_output_stage_model_inst (.clk_sys(clk_sys), .nrst(nrst),
		.convData(convData), .holdSampling(holdSampling), .bypassHold(bypassHold),
		.heldValue0(heldValue0), .heldValue1(heldValue1));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// whole run needs under 1000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			numErrors++;
			$display("MISMATCH t=%0t timeout", $time);
			endOfTest();
		end
	end

	task endOfTest();
		$display("errors %0d checks %0d", numErrors, samplesChecked);
		if (numErrors == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one-cycle strobes, entered and left just after a falling edge
	task pulse(input logic [1:0] ev, input logic [1:0] lo, input logic [1:0] hi, input logic [7:0] d);
		eventTrig = ev;
		lowWrite = lo;
		highWrite = hi;
		wrData = d;
		@(negedge clk_sys);
		eventTrig = 2'h0;
		lowWrite = 2'h0;
		highWrite = 2'h0;
	endtask

	// low then high byte on back-to-back cycles; each strobe set and cleared once
	task writeBytes(input logic [1:0] ch, input logic [7:0] lo, input logic [7:0] hi);
		lowWrite = ch;
		wrData = lo;
		@(negedge clk_sys);
		lowWrite = 2'h0;
		highWrite = ch;
		wrData = hi;
		@(negedge clk_sys);
		highWrite = 2'h0;
	endtask

	// falling edges until convStart, -1 if none within lim
	task automatic waitStart(input int lim, output int cnt);
		cnt = 0;
		do begin
			@(negedge clk_sys);
			cnt++;
		end while (convStart !== 1'b1 && cnt < lim);
		if (convStart !== 1'b1)
			cnt = -1;
	endtask

	task singleWrite();
		writeBytes(2'h1, 8'hBC, 8'h0A);
		waitStart(40, n);
		`CHK(n, 2)
		`CHK(convData, 12'hABC)
		`CHK(convChannel, 1'b0)
		`CHK(holdSampling, 2'h0)
		repeat (20) @(negedge clk_sys);
		`CHK(heldValue0, 12'hABC)
		pulse(2'h2, 2'h0, 2'h0, 8'h00);
		waitStart(20, n);
		`CHK(n, -1)
	endtask

	task leftWrite();
		leftAlignBit = 1'b1;
		pulse(2'h0, 2'h0, 2'h1, 8'h5A);
		waitStart(40, n);
		`CHK(n, 2)
		`CHK(convData[11:4], 8'h5A)
		`CHK(convData, 12'h5AB)
		repeat (20) @(negedge clk_sys);
		leftAlignBit = 1'b0;
	endtask

	task dualPair();
		channelSelectField = 2'h2;
		@(negedge clk_sys);
		`CHK(outEnable, 2'h3)
		`CHK(bypassHold, 1'b0)
		writeBytes(2'h2, 8'h21, 8'h03);
		waitStart(40, n);
		`CHK(n, 2)
		`CHK(convChannel, 1'b1)
		repeat (20) @(negedge clk_sys);
		pulse(2'h3, 2'h0, 2'h0, 8'h00);
		waitStart(40, n);
		`CHK(n, 1)
		`CHK(convChannel, 1'b0)
		`CHK(holdSampling, 2'h1)
		k = 0;
		while (convBusy === 1'b1 && k < 40) begin
			@(negedge clk_sys);
			k++;
		end
		`CHK(k, 16)
		waitStart(40, n);
		`CHK(n, 1)
		`CHK(convData, 12'h321)
		`CHK(holdSampling, 2'h2)
		repeat (20) @(negedge clk_sys);
		`CHK(heldValue0, 12'hABC)
		`CHK(heldValue1, 12'h321)
	endtask

	// extra conversion between refreshes must not move the next one
	task refreshRun();
		refreshTimingField = 4'h1;
		waitStart(200, n);
		`CHK(convChannel, 1'b0)
		t0 = $time;
		waitStart(40, n);
		`CHK(n, 17)
		`CHK(convChannel, 1'b1)
		repeat (19) @(negedge clk_sys);
		pulse(2'h2, 2'h0, 2'h0, 8'h00);
		waitStart(40, n);
		`CHK(n, 1)
		waitStart(80, n);
		`CHK(convChannel, 1'b0)
		`CHK(int'(($time - t0) / 20), 64)
		refreshTimingField = 4'h0;
	endtask

	initial begin
		nrst = 1'b0;
		channelSelectField = 2'h0;
		refreshTimingField = 4'h0;
		leftAlignBit = 1'b0;
		lowWrite = 2'h0;
		highWrite = 2'h0;
		wrData = 8'h00;
		eventTrig = 2'h0;
		repeat (8) @(negedge clk_sys);
		`CHK(bypassHold, 1'b1)
		`CHK(outEnable, 2'h0)
		nrst = 1'b1;
		@(negedge clk_sys);
		`CHK(outEnable, 2'h1)
		singleWrite();
		leftWrite();
		dualPair();
		refreshRun();
		endOfTest();
	end
endmodule

`default_nettype wire
